// ===== core/pn_pkg.sv
package pn_pkg;

  // Bus geometry: byte address is four times the register index
  localparam int ADR_W = 18;
  localparam int IDX_W = 16;

  // Register indices as printed
  localparam logic [15:0] DIR_INDEX = 16'hffd0;
  localparam logic [15:0] VALUE_INDEX = 16'hffd2;

  // Values after reset and hardware standby
  localparam logic [7:0] DIR_RESET = 8'hc0;
  localparam logic [7:0] VALUE_RESET = 8'hc0;

  // Read patterns
  localparam logic [7:0] DIR_READ = 8'hff;
  localparam logic [7:0] FIXED_ONES = 8'hc0;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Bits that reach a pin (4, 2, 0) and spare storage bits (5, 3, 1)
  localparam logic [5:0] PIN_BITS = 6'h15;
  localparam logic [5:0] SPARE_BITS = 6'h2a;

  // Field positions of the three pins in the data register
  localparam int BIT_PIN_FOUR = 4;
  localparam int BIT_PIN_TWO = 2;
  localparam int BIT_PIN_ZERO = 0;

  // Pad vector positions of the three pins
  localparam int PAD_FOUR = 2;
  localparam int PAD_TWO = 1;
  localparam int PAD_ZERO = 0;

  // Controls that the serial comm unit hands to the port
  typedef struct packed {
    logic sck_in_mode;
    logic sck_out_mode;
    logic sck_out;
    logic rx_en;
    logic tx_en;
    logic tx_data;
  } pn_serial_s;

  // Pad drive: level and active-low output enable per pin
  typedef struct packed {
    logic [2:0] level;
    logic [2:0] oe_n;
  } pn_pad_s;

endpackage : pn_pkg

// ===== core/pn_port_nine.sv
// Operation
// - Three pins at port bits 4, 2, 0
// - Pins shared with serial unit and interrupt
// - Direction 1 drives output, 0 is input
// - Direction register reads as all ones
// - Direction loads 0xc0 on reset, hardware standby
// - Software standby holds driven output levels
// - Output pins read back stored value
// - Input pins read back live level
// - Bits 7 and 6 fixed at one
// - Spare bits 5, 3, 1 store only
// - Spare bits read one when direction zero
// - Data loads 0xc0 on reset, hardware standby
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps

module pn_port_nine (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hw_standby_i,
  input wire logic sw_standby_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [pn_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [2:0] pad_i,
  output pn_pkg::pn_pad_s pad_o,
  input wire pn_pkg::pn_serial_s serial_i,
  output logic serial_rxd_o,
  output logic serial_sck_o,
  output logic external_interrupt_line_four_n_o
);

  // Stored register bits; bits 7 and 6 are constants
  logic [5:0] dir;
  logic [5:0] next_dir;
  logic [5:0] value;
  logic [5:0] next_value;

  // Bus answer state
  logic ack;
  logic next_ack;
  logic [7:0] rdata;
  logic [7:0] next_rdata;

  // Pad and level outputs
  pn_pkg::pn_pad_s pad;
  pn_pkg::pn_pad_s next_pad;
  logic rxd;
  logic next_rxd;
  logic sck;
  logic next_sck;
  logic irq_n;
  logic next_irq_n;

  // Decode; the low two address bits are ignored
  logic access;
  logic hit_dir;
  logic hit_val;
  logic wr;
  logic [7:0] port_view;

  assign access = wb_cyc_i & wb_stb_i;
  assign hit_dir = wb_adr_i[pn_pkg::ADR_W-1:2] == pn_pkg::DIR_INDEX;
  assign hit_val = wb_adr_i[pn_pkg::ADR_W-1:2] == pn_pkg::VALUE_INDEX;
  // Write lands at the edge the master samples ack; only lane 0 holds data
  assign wr = access & wb_we_i & ack & wb_sel_i[0];

  // Register next values; hardware standby wins over any write
  always_comb begin
    next_dir = dir;
    next_value = value;
    if (hw_standby_i) begin
      next_dir = pn_pkg::DIR_RESET[5:0];
      next_value = pn_pkg::VALUE_RESET[5:0];
    end else if (wr && hit_dir) begin
      next_dir = wb_dat_i[5:0];
    end else if (wr && hit_val) begin
      next_value = wb_dat_i[5:0];
    end
  end

  // Read view of the data register
  always_comb begin
    port_view = pn_pkg::FIXED_ONES;
    for (int i = 0; i < 6; i++) begin
      if (dir[i]) begin
        port_view[i] = value[i];
      end else if (pn_pkg::PIN_BITS[i]) begin
        port_view[i] = pad_i[i/2];
      end else begin
        port_view[i] = 1'b1;
      end
    end
  end

  // Bus slave: one wait state, ack lasts one cycle, unmapped reads zero
  always_comb begin
    next_ack = access & ~ack;
    next_rdata = rdata;
    if (access && !ack) begin
      if (hit_dir) begin
        next_rdata = pn_pkg::DIR_READ;
      end else if (hit_val) begin
        next_rdata = port_view;
      end else begin
        next_rdata = pn_pkg::UNMAPPED_READ;
      end
    end
  end

  // Pin functions from the next register values so pins move with them
  always_comb begin
    next_pad.oe_n = 3'h7;
    next_pad.level = 3'h0;
    // Pin four: clock line of the serial unit or plain port bit
    if (serial_i.sck_in_mode) begin
      next_pad.oe_n[pn_pkg::PAD_FOUR] = 1'b1;
    end else if (serial_i.sck_out_mode) begin
      next_pad.oe_n[pn_pkg::PAD_FOUR] = 1'b0;
      next_pad.level[pn_pkg::PAD_FOUR] = serial_i.sck_out;
    end else begin
      next_pad.oe_n[pn_pkg::PAD_FOUR] = ~next_dir[pn_pkg::BIT_PIN_FOUR];
      next_pad.level[pn_pkg::PAD_FOUR] = next_value[pn_pkg::BIT_PIN_FOUR];
    end
    // Pin two: receive line overrides the port when enabled
    if (serial_i.rx_en) begin
      next_pad.oe_n[pn_pkg::PAD_TWO] = 1'b1;
    end else begin
      next_pad.oe_n[pn_pkg::PAD_TWO] = ~next_dir[pn_pkg::BIT_PIN_TWO];
      next_pad.level[pn_pkg::PAD_TWO] = next_value[pn_pkg::BIT_PIN_TWO];
    end
    // Pin zero: transmit line overrides the port when enabled
    if (serial_i.tx_en) begin
      next_pad.oe_n[pn_pkg::PAD_ZERO] = 1'b0;
      next_pad.level[pn_pkg::PAD_ZERO] = serial_i.tx_data;
    end else begin
      next_pad.oe_n[pn_pkg::PAD_ZERO] = ~next_dir[pn_pkg::BIT_PIN_ZERO];
      next_pad.level[pn_pkg::PAD_ZERO] = next_value[pn_pkg::BIT_PIN_ZERO];
    end
    // Software standby freezes the whole pad state, not just port bits
    if (sw_standby_i) begin
      next_pad = pad;
    end
  end

  // Levels handed to the serial unit and interrupt logic, one cycle late
  always_comb begin
    next_rxd = pad_i[pn_pkg::PAD_TWO];
    next_sck = pad_i[pn_pkg::PAD_FOUR];
    next_irq_n = pad_i[pn_pkg::PAD_FOUR];
  end

  // State registers; reset takes constants only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dir <= pn_pkg::DIR_RESET[5:0];
      value <= pn_pkg::VALUE_RESET[5:0];
      ack <= 1'b0;
      rdata <= 8'h00;
      pad.oe_n <= 3'h7;
      pad.level <= 3'h0;
      rxd <= 1'b1;
      sck <= 1'b1;
      irq_n <= 1'b1;
    end else begin
      dir <= next_dir;
      value <= next_value;
      ack <= next_ack;
      rdata <= next_rdata;
      pad <= next_pad;
      rxd <= next_rxd;
      sck <= next_sck;
      irq_n <= next_irq_n;
    end
  end

  // Outputs straight from flops; upper data lanes read zero
  assign wb_ack_o = ack;
  assign wb_dat_o = {24'h000000, rdata};
  assign pad_o = pad;
  assign serial_rxd_o = rxd;
  assign serial_sck_o = sck;
  assign external_interrupt_line_four_n_o = irq_n;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Completed data register write
  sequence s_value_write;
    ack && wb_we_i && hit_val && wb_sel_i[0] && !hw_standby_i;
  endsequence

  // Completed direction register write
  sequence s_dir_write;
    ack && wb_we_i && hit_dir && wb_sel_i[0] && !hw_standby_i;
  endsequence

  // Read answer of the data register
  sequence s_value_read;
    ack && !wb_we_i && hit_val;
  endsequence

  a_ack_single_pulse: assert property (ack |=> !ack)
    else $error("ack held longer than one cycle");

  a_dir_reads_ones: assert property (
    ack && !wb_we_i && hit_dir |-> wb_dat_o[7:0] == 8'hff)
    else $error("direction read not all ones");

  a_hw_standby_dir: assert property (
    hw_standby_i |=> dir == 6'h00)
    else $error("direction not reloaded in hardware standby");

  a_hw_standby_value: assert property (
    hw_standby_i |=> value == pn_pkg::VALUE_RESET[5:0])
    else $error("data not reloaded in hardware standby");

  a_sw_standby_hold: assert property (
    sw_standby_i |=> $stable(pad))
    else $error("pads moved in software standby");

  a_pin_zero_drive: assert property (
    !sw_standby_i && !serial_i.tx_en && next_dir[0] |=>
      !pad.oe_n[0] && pad.level[0] == value[0])
    else $error("pin zero not driving stored bit");

  a_pin_zero_input: assert property (
    !sw_standby_i && !serial_i.tx_en && !next_dir[0] |=> pad.oe_n[0])
    else $error("pin zero driving while input");

  a_tx_on_pin: assert property (
    !sw_standby_i && serial_i.tx_en |=>
      !pad.oe_n[0] && pad.level[0] == $past(serial_i.tx_data))
    else $error("transmit data not on pin zero");

  a_fixed_ones: assert property (
    s_value_read |-> wb_dat_o[7:6] == 2'b11)
    else $error("data bits 7 and 6 not one");

  a_out_readback: assert property (
    s_value_read and $past(dir[4]) |-> wb_dat_o[4] == $past(value[4]))
    else $error("output pin did not read stored bit");

  a_in_readback: assert property (
    s_value_read and !$past(dir[2]) |-> wb_dat_o[2] == $past(pad_i[1]))
    else $error("input pin did not read pin level");

  a_spare_reads_one: assert property (
    s_value_read and !$past(dir[3]) |-> wb_dat_o[3])
    else $error("spare bit not one with direction zero");

  a_spare_store: assert property (
    s_value_write |=> value[5] == $past(wb_dat_i[5]))
    else $error("spare bit 5 not stored");

  a_dir_write_pins: assert property (
    s_dir_write ##0 (!sw_standby_i && !serial_i.rx_en) |=>
      dir == $past(wb_dat_i[5:0]) && pad.oe_n[1] == !dir[2])
    else $error("direction write not on pin in same cycle");

  // Port drive on pins two and four when the serial unit leaves them alone
  a_pin_two_drive: assert property (
    !sw_standby_i && !serial_i.rx_en && next_dir[2] |=>
      !pad.oe_n[1] && pad.level[1] == value[2])
    else $error("pin two not driving stored bit");

  a_pin_four_drive: assert property (
    !sw_standby_i && !serial_i.sck_in_mode && !serial_i.sck_out_mode && next_dir[4] |=>
      !pad.oe_n[2] && pad.level[2] == value[4])
    else $error("pin four not driving stored bit");

  // Serial unit overrides win over the port direction
  a_sck_out_pin: assert property (
    !sw_standby_i && !serial_i.sck_in_mode && serial_i.sck_out_mode |=>
      !pad.oe_n[2] && pad.level[2] == $past(serial_i.sck_out))
    else $error("serial clock not on pin four");

  a_sck_in_pin: assert property (
    !sw_standby_i && serial_i.sck_in_mode |=> pad.oe_n[2])
    else $error("pin four driving while clock input");

  a_rx_pin_input: assert property (
    !sw_standby_i && serial_i.rx_en |=> pad.oe_n[1])
    else $error("pin two driving while receive enabled");

  // Level copies; the reset edge itself is skipped since the copies load ones there
  a_rxd_copy: assert property (
    !rst_i |=> serial_rxd_o == $past(pad_i[pn_pkg::PAD_TWO]))
    else $error("receive level not passed on");

  a_sck_copy: assert property (
    !rst_i |=> serial_sck_o == $past(pad_i[pn_pkg::PAD_FOUR]))
    else $error("clock level not passed on");

  a_irq_copy: assert property (
    !rst_i |=> external_interrupt_line_four_n_o == $past(pad_i[pn_pkg::PAD_FOUR]))
    else $error("interrupt level not passed on");

  a_spare_low_store: assert property (
    s_value_write |=> value[3] == $past(wb_dat_i[3]) && value[1] == $past(wb_dat_i[1]))
    else $error("spare bits 3 and 1 not stored");

  a_unmapped_zero: assert property (
    ack && !wb_we_i && !hit_dir && !hit_val |-> wb_dat_o == 32'h00000000)
    else $error("unmapped read not zero");

endmodule : pn_port_nine

// ===== verification/pn_pin_model.sv
`timescale 1ns/1ps

// Far side of the pads: outside logic drives every pin, the port wins where it drives
module pn_pin_model (
  input wire pn_pkg::pn_pad_s pad_o,
  input wire logic [2:0] ext_i,
  output logic [2:0] pad_i
);
  // Wire level from both parties; oe_n low means the port drives
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      pad_i[k] = pad_o.oe_n[k] ? ext_i[k] : pad_o.level[k];
    end
  end
endmodule : pn_pin_model

// ===== verification/three_bit_io_port_nine_test.sv
`timescale 1ns/1ps

module three_bit_io_port_nine_test;
  localparam logic [17:0] A_DIR = {pn_pkg::DIR_INDEX, 2'b00};
  localparam logic [17:0] A_VAL = {pn_pkg::VALUE_INDEX, 2'b00};
  logic clk_i = 0, rst_i = 1, hw_standby_i = 0, sw_standby_i = 0;
  logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, rxd, sck, irq_n;
  logic [17:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = '0;
  logic [31:0] wb_dat_i = '0, wb_dat_o, q, keep;
  logic [2:0] pad_i, ext = 3'h0;
  pn_pkg::pn_pad_s pad_o;
  pn_pkg::pn_serial_s serial_i = '0;
  int err_total = 0, n_compared = 0, dir = 0, dat = 'hc0;

  always #25 clk_i = ~clk_i;

  pn_port_nine uut (.clk_i(clk_i), .rst_i(rst_i), .hw_standby_i(hw_standby_i),
    .sw_standby_i(sw_standby_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pad_i(pad_i), .pad_o(pad_o),
    .serial_i(serial_i), .serial_rxd_o(rxd), .serial_sck_o(sck),
    .external_interrupt_line_four_n_o(irq_n));

  pn_pin_model pins (.pad_o(pad_o), .ext_i(ext), .pad_i(pad_i));

  task end_of_test;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Classic single cycle; holds everything until ack is sampled high
  task bus(input logic we, input logic [17:0] a, input logic [7:0] d, input logic [3:0] s);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i} <= {2'b11, we, a, s};
    wb_dat_i <= {24'h0, d};
    // Only the watchdog ends a wait for ack
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask : bus

  // Write and keep the model in step; bits 7:6 never change
  task wr(input logic [17:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
    if (a == A_DIR) dir = d;
    else dat = 'hc0 | (d & 'h3f);
  endtask : wr

  function automatic logic [31:0] view();
    logic [7:0] v;
    v = 8'hc0;
    for (int i = 0; i < 6; i++) v[i] = dir[i] ? dat[i] : ((i % 2 == 0) ? ext[i / 2] : 1'b1);
    return {24'h0, v};
  endfunction : view

  task rd(input logic [17:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00, 4'h1);
    check(q, exp);
  endtask : rd

  function automatic logic [31:0] pads();
    return {26'h0, 1'(dat[4]), 1'(dat[2]), 1'(dat[0]), 1'(~dir[4]), 1'(~dir[2]), 1'(~dir[0])};
  endfunction : pads

  initial begin
    #100000;
    err_total++;
    $display("Watchdog expired");
    end_of_test;
  end

  initial begin
    void'($urandom(56));
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    rd(A_VAL, view());
    @(negedge clk_i);
    check({26'h0, pad_o}, pads());
    $display("Reset test done");
    for (int t = 0; t < 12; t++) begin
      ext <= 3'($urandom);
      wr(A_DIR, 8'($urandom));
      wr(A_VAL, 8'($urandom));
      @(negedge clk_i);
      check({26'h0, pad_o}, pads());
      rd(A_VAL, view());
      rd(A_DIR, pn_pkg::DIR_READ);
      check({31'h0, irq_n}, 32'(dir[4] ? dat[4] : ext[2]));
      check({31'h0, rxd}, 32'(dir[2] ? dat[2] : ext[1]));
    end
    bus(1'b1, A_VAL, 8'h2a, 4'h0);
    rd(A_VAL, view());
    rd(A_VAL + 18'h8, 32'h0);
    $display("Register test done");
    wr(A_DIR, 8'h3f);
    wr(A_VAL, 8'h15);
    keep = pads();
    sw_standby_i <= 1;
    wr(A_VAL, 8'h2a);
    ext <= 3'h5;
    repeat (2) @(negedge clk_i);
    check({26'h0, pad_o}, keep);
    rd(A_VAL, view());
    sw_standby_i <= 0;
    repeat (2) @(negedge clk_i);
    check({26'h0, pad_o}, pads());
    $display("Software standby test done");
    @(posedge clk_i);
    hw_standby_i <= 1;
    bus(1'b1, A_DIR, 8'h3f, 4'h1);
    bus(1'b1, A_VAL, 8'h3f, 4'h1);
    hw_standby_i <= 0;
    dir = 0;
    dat = 'hc0;
    rd(A_VAL, view());
    @(negedge clk_i);
    check({26'h0, pad_o}, pads());
    $display("Hardware standby test done");
    wr(A_DIR, 8'h15);
    wr(A_VAL, 8'h15);
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    dir = 0;
    dat = 'hc0;
    rd(A_VAL, view());
    @(negedge clk_i);
    check({26'h0, pad_o}, pads());
    $display("Mid-run reset test done");
    @(posedge clk_i);
    serial_i <= 6'b000011;
    repeat (3) @(negedge clk_i);
    check({30'h0, pad_o.level[0], pad_o.oe_n[0]}, 32'h2);
    // Clock out on pin four, receive on pin two, port keeps pin zero
    wr(A_DIR, 8'h15);
    wr(A_VAL, 8'h00);
    ext <= 3'h2;
    serial_i <= 6'b011100;
    repeat (3) @(negedge clk_i);
    check({26'h0, pad_o}, 32'h22);
    check({29'h0, rxd, sck, irq_n}, 32'h7);
    rd(A_VAL, view());
    // Clock in on pin four: the pin is released and its level passed on
    serial_i <= 6'b100000;
    ext <= 3'h0;
    repeat (3) @(negedge clk_i);
    check({26'h0, pad_o}, 32'h04);
    check({29'h0, rxd, sck, irq_n}, 32'h0);
    $display("Serial test done");
    end_of_test;
  end
endmodule : three_bit_io_port_nine_test
